// ===== src/eir_pkg.sv
// shared constants and state type for the two-wire eeprom read engine
package eir_pkg;
  localparam int         ARR_AW     = 17;       // main array address width
  localparam int         ID_AW      = 8;        // identification page location width
  localparam logic [3:0] TYPE_ARRAY = 4'hA;     // device type for the main array
  localparam logic [3:0] TYPE_ID    = 4'hB;     // device type for the identification page
  localparam logic [7:0] ERASED     = 8'hFF;    // delivered content of every byte
  localparam int         CE_POS     = 2;        // chip-enable pair in the select byte
  localparam int         A16_POS    = 1;        // top array address bit in the select byte
  localparam int         RW_POS     = 0;        // direction bit in the select byte
  localparam logic [2:0] LAST_BIT   = 3'h7;     // bit index of the eighth bit of a byte

  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV, ST_AHI, ST_ALO, ST_WDAT, ST_ACK, ST_RDATA, ST_RACK, ST_IGNORE
  } eir_state_e;
endpackage : eir_pkg

// ===== src/eir_mem.sv
// byte memory with registered read data, filled with the erased value
`timescale 1ns/1ps
module eir_mem #(
  parameter int AW = 8
) (
  input  wire logic          i_clk,
  input  wire logic          i_ce,
  input  wire logic [AW-1:0] i_addr,
  output logic [7:0]         o_rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  initial
  begin
    for (int i = 0; i < (1 << AW); i++)
    begin
      mem[i] = eir_pkg::ERASED;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_ce)
    begin
      o_rdata <= mem[i_addr];
    end
  end
endmodule : eir_mem

// ===== src/eir_read_engine.sv
// read-side protocol engine of a two-wire eeprom target, oversampling the bus
// What this block does
// - reads behave identically whatever the write-protect level is
// - a completed read byte advances the address counter by one
// - after each read byte, master no-ack sends the device to standby
// - random read: dummy write loads address, repeated start, read select, byte driven
// - current read: select with read bit, drive byte at counter, then increment
// - one counter serves both array and identification page
// - while the master acknowledges, the next byte keeps being driven
// - counter increments after every read byte and wraps to 00h past the top
// - type 1011b selects the id page; only the low address byte is used
// - id page write data byte is acked when unlocked, not acked when locked
// - start abandons any command, stop returns to standby
// - every array and id page byte is delivered as FFh
// - last select bit gives direction: 1 read, 0 write
// - respond only when chip-enable bits match the two pin levels
// - 17-bit array address: two address bytes plus top bit in select byte
// - during an internal write cycle the device ignores every request
`timescale 1ns/1ps
module eir_read_engine #(
  parameter int AW = eir_pkg::ARR_AW
) (
  input  wire logic          i_clk,
  input  wire logic          i_reset,
  input  wire logic          i_ce,
  input  wire logic          i_scl,
  input  wire logic          i_sda,
  input  wire logic          i_chip_select_pin_low,
  input  wire logic          i_chip_select_pin_high,
  input  wire logic          i_write_protect_n,
  input  wire logic          i_write_busy,
  input  wire logic          i_id_locked,
  output logic               o_sda_o,
  output logic               o_sda_oe,
  output logic [AW-1:0]      o_addr_counter,
  output logic               o_id_mode
);
  // the address load concatenation only fits the documented array width
  if (AW != eir_pkg::ARR_AW)
  begin : g_bad_aw
    $error("address width must equal the array address width");
  end

  // two-flop synchronisers, plus a third stage for edge detection
  logic scl_m_r, scl_s_r, scl_d_r;
  logic sda_m_r, sda_s_r, sda_d_r;
  // strap and write-protect pins are asynchronous as well: {high, low, protect}
  logic [2:0] pins_m_r, pins_s_r;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
      // protect set out of reset, so no array write data is acked before the pin settles
      pins_m_r <= 3'h1;
      pins_s_r <= 3'h1;
    end
    else if (i_ce)
    begin
      scl_m_r <= i_scl;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= i_sda;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
      pins_m_r <= {i_chip_select_pin_high, i_chip_select_pin_low, i_write_protect_n};
      pins_s_r <= pins_m_r;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_s_r & ~scl_d_r;
  assign scl_fall  = ~scl_s_r & scl_d_r;
  assign bus_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign bus_stop  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  eir_pkg::eir_state_e st_r, st_nxt, after_r, after_nxt;
  logic [2:0]    bit_r, bit_nxt;
  logic          got_r, got_nxt;
  logic [7:0]    sh_r, sh_nxt;
  logic [7:0]    out_r, out_nxt;
  logic [7:0]    hi_r, hi_nxt;
  logic          a16_r, a16_nxt;
  logic          id_sel_r, id_sel_nxt;
  logic          id_mode_r, id_mode_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic          oe_r, oe_nxt;
  logic [7:0]    arr_q, id_q, mem_q;

  eir_mem #(.AW(AW)) u_array (
    .i_clk   (i_clk),
    .i_ce    (i_ce),
    .i_addr  (addr_r),
    .o_rdata (arr_q)
  );

  eir_mem #(.AW(eir_pkg::ID_AW)) u_id_page (
    .i_clk   (i_clk),
    .i_ce    (i_ce),
    .i_addr  (addr_r[eir_pkg::ID_AW-1:0]),
    .o_rdata (id_q)
  );

  assign mem_q = id_mode_r ? id_q : arr_q;

  function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a, input logic in_id);
    logic [AW-1:0] r;
    r = a + AW'(1);
    if (in_id)
    begin
      r = {a[AW-1:eir_pkg::ID_AW], a[eir_pkg::ID_AW-1:0] + 8'h01};
    end
    return r;
  endfunction : next_addr

  logic [3:0] dev_type;
  logic       ce_match, type_ok;
  assign dev_type = sh_r[7:4];
  assign type_ok  = (dev_type == eir_pkg::TYPE_ARRAY) || (dev_type == eir_pkg::TYPE_ID);
  assign ce_match = sh_r[eir_pkg::CE_POS +: 2] == pins_s_r[2:1];

  always_comb
  begin
    st_nxt      = st_r;
    after_nxt   = after_r;
    bit_nxt     = bit_r;
    got_nxt     = got_r;
    sh_nxt      = sh_r;
    out_nxt     = out_r;
    hi_nxt      = hi_r;
    a16_nxt     = a16_r;
    id_sel_nxt  = id_sel_r;
    id_mode_nxt = id_mode_r;
    addr_nxt    = addr_r;
    oe_nxt      = oe_r;
    if (bus_start)
    begin
      st_nxt  = eir_pkg::ST_DEV;
      oe_nxt  = 1'b0;
      bit_nxt = 3'h0;
      got_nxt = 1'b0;
    end
    else if (bus_stop)
    begin
      st_nxt = eir_pkg::ST_IDLE;
      oe_nxt = 1'b0;
    end
    else
    begin
      case (st_r)
        eir_pkg::ST_DEV, eir_pkg::ST_AHI, eir_pkg::ST_ALO, eir_pkg::ST_WDAT:
        begin
          if (scl_rise)
          begin
            sh_nxt  = {sh_r[6:0], sda_s_r};
            bit_nxt = bit_r + 3'h1;
            got_nxt = (bit_r == eir_pkg::LAST_BIT);
          end
          else if (scl_fall && got_r)
          begin
            got_nxt = 1'b0;
            bit_nxt = 3'h0;
            st_nxt  = eir_pkg::ST_ACK;
            oe_nxt  = 1'b1;
            case (st_r)
              eir_pkg::ST_DEV:
              begin
                if (!type_ok || !ce_match || i_write_busy)
                begin
                  st_nxt = eir_pkg::ST_IGNORE;
                  oe_nxt = 1'b0;
                end
                else if (sh_r[eir_pkg::RW_POS])
                begin
                  after_nxt   = eir_pkg::ST_RDATA;
                  id_mode_nxt = (dev_type == eir_pkg::TYPE_ID);
                end
                else
                begin
                  after_nxt  = eir_pkg::ST_AHI;
                  a16_nxt    = sh_r[eir_pkg::A16_POS];
                  id_sel_nxt = (dev_type == eir_pkg::TYPE_ID);
                end
              end
              eir_pkg::ST_AHI:
              begin
                hi_nxt    = sh_r;
                after_nxt = eir_pkg::ST_ALO;
              end
              eir_pkg::ST_ALO:
              begin
                after_nxt   = eir_pkg::ST_WDAT;
                id_mode_nxt = id_sel_r;
                if (id_sel_r)
                begin
                  addr_nxt = AW'(sh_r);
                end
                else
                begin
                  addr_nxt = {a16_r, hi_r, sh_r};
                end
              end
              default:
              begin
                after_nxt = eir_pkg::ST_WDAT;
                // lock probe: the ack tells software whether the page is locked
                oe_nxt    = id_sel_r ? !i_id_locked : !pins_s_r[0];
              end
            endcase
          end
        end
        eir_pkg::ST_ACK:
        begin
          if (scl_fall)
          begin
            st_nxt = after_r;
            oe_nxt = 1'b0;
            if (after_r == eir_pkg::ST_RDATA)
            begin
              out_nxt = {mem_q[6:0], 1'b0};
              oe_nxt  = !mem_q[7];
              bit_nxt = 3'h0;
            end
          end
        end
        eir_pkg::ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (bit_r == eir_pkg::LAST_BIT)
            begin
              st_nxt   = eir_pkg::ST_RACK;
              oe_nxt   = 1'b0;
              addr_nxt = next_addr(addr_r, id_mode_r);
            end
            else
            begin
              bit_nxt = bit_r + 3'h1;
              oe_nxt  = !out_r[7];
              out_nxt = {out_r[6:0], 1'b0};
            end
          end
        end
        eir_pkg::ST_RACK:
        begin
          if (scl_rise)
          begin
            if (sda_s_r)
            begin
              st_nxt = eir_pkg::ST_IGNORE;
            end
            else
            begin
              st_nxt    = eir_pkg::ST_ACK;
              after_nxt = eir_pkg::ST_RDATA;
            end
          end
        end
        default:
        begin
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      st_r      <= eir_pkg::ST_IDLE;
      after_r   <= eir_pkg::ST_IDLE;
      bit_r     <= 3'h0;
      got_r     <= 1'b0;
      sh_r      <= 8'h00;
      out_r     <= 8'h00;
      hi_r      <= 8'h00;
      a16_r     <= 1'b0;
      id_sel_r  <= 1'b0;
      id_mode_r <= 1'b0;
      addr_r    <= '0;
      oe_r      <= 1'b0;
    end
    else if (i_ce)
    begin
      st_r      <= st_nxt;
      after_r   <= after_nxt;
      bit_r     <= bit_nxt;
      got_r     <= got_nxt;
      sh_r      <= sh_nxt;
      out_r     <= out_nxt;
      hi_r      <= hi_nxt;
      a16_r     <= a16_nxt;
      id_sel_r  <= id_sel_nxt;
      id_mode_r <= id_mode_nxt;
      addr_r    <= addr_nxt;
      oe_r      <= oe_nxt;
    end
  end

  // open drain: the pad value is a constant low register, only the enable moves
  always_ff @(posedge i_clk)
  begin
    o_sda_o <= 1'b0;
  end

  assign o_sda_oe       = oe_r;
  assign o_addr_counter = addr_r;
  assign o_id_mode      = id_mode_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_byte_end;
    i_ce && st_r == eir_pkg::ST_RDATA && scl_fall && bit_r == eir_pkg::LAST_BIT;
  endsequence

  sequence s_master_nack;
    i_ce && st_r == eir_pkg::ST_RACK && scl_rise && sda_s_r && !bus_start && !bus_stop;
  endsequence

  a_busy_no_ack: assert property (
    (i_ce && st_r == eir_pkg::ST_DEV && got_r && scl_fall && i_write_busy && !bus_start
     && !bus_stop) |=> (!o_sda_oe && st_r == eir_pkg::ST_IGNORE))
    else $error("select acknowledged during write cycle");

  a_ce_mismatch: assert property (
    (i_ce && st_r == eir_pkg::ST_DEV && got_r && scl_fall && !ce_match && !bus_start
     && !bus_stop) |=> st_r == eir_pkg::ST_IGNORE)
    else $error("select with wrong chip enable not ignored");

  a_nack_standby: assert property (
    s_master_nack |=> (st_r == eir_pkg::ST_IGNORE && !o_sda_oe) [*2])
    else $error("no-ack did not end the read");

  a_array_inc: assert property (
    (s_byte_end and (!id_mode_r && !bus_start && !bus_stop))
      |=> addr_r == AW'($past(addr_r) + AW'(1)))
    else $error("array counter not incremented by one");

  a_id_page_wrap: assert property (
    (s_byte_end and (id_mode_r && !bus_start && !bus_stop))
      |=> (addr_r[AW-1:8] == $past(addr_r[AW-1:8])
           && addr_r[7:0] == 8'($past(addr_r[7:0]) + 8'h01)))
    else $error("id page counter left its page");

  a_start_reset: assert property (
    (i_ce && bus_start) |=> (st_r == eir_pkg::ST_DEV && !o_sda_oe && bit_r == 3'h0))
    else $error("start did not reset the engine");

  a_stop_idle: assert property (
    (i_ce && bus_stop) |=> (st_r == eir_pkg::ST_IDLE && !o_sda_oe))
    else $error("stop did not return to standby");

  a_lock_ack: assert property (
    (i_ce && st_r == eir_pkg::ST_WDAT && got_r && scl_fall && id_sel_r && !bus_start
     && !bus_stop) |=> o_sda_oe == !$past(i_id_locked))
    else $error("lock probe answer wrong");

  a_sda_scl_low: assert property (
    (st_r == eir_pkg::ST_RDATA && $changed(o_sda_oe)) |-> !scl_s_r)
    else $error("read data changed while clock high");

  a_ce_freeze: assert property (
    !i_ce |=> ($stable(addr_r) && $stable(o_sda_oe)))
    else $error("state moved while clock enable low");
endmodule : eir_read_engine

// ===== verif/eir_bus_master.sv
// two-wire bus master model that clocks the link from outside the system clock domain
`timescale 1ns/1ps
module eir_bus_master (
  input  wire logic i_sda_line,
  output logic      o_scl,
  output logic      o_sda_oe
);
  // bus idles released with the clock line high; the clock stands still between frames
  initial
  begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end

  // data changes 50 ns into the low phase; sampled mid-high, after the target's ~200 ns lag
  task automatic bit_cycle(input logic drive_low, output logic seen);
    #50 o_sda_oe = drive_low;
    #150 o_scl = 1'b1;
    #100 seen = i_sda_line;
    #100 o_scl = 1'b0;
  endtask : bit_cycle

  // the target may still hold its ack for ~200 ns, so clock rises late to avoid a false stop
  task automatic start_cond();
    #50 o_sda_oe = 1'b0;
    #250 o_scl = 1'b1;
    #200 o_sda_oe = 1'b1;
    #200 o_scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    #50 o_sda_oe = 1'b1;
    #250 o_scl = 1'b1;
    #200 o_sda_oe = 1'b0;
    #200;
  endtask : stop_cond

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cycle(~b[i], s);
    bit_cycle(1'b0, s);
    ack = ~s;
  endtask : wr_byte

  task automatic rd_byte(input logic give_ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cycle(1'b0, d[i]);
    bit_cycle(give_ack, s);
  endtask : rd_byte
endmodule : eir_bus_master

// ===== verif/tb_eeprom_i2c_read_engine.sv
// self-checking bench for the read engine against a bus master model and a counter model
`timescale 1ns/1ps
module tb_eeprom_i2c_read_engine;
  logic        clk, rst, ce, scl, m_oe, ce_lo, ce_hi, wp_n, busy, locked;
  logic        sda_o, sda_oe, id_mode, ack, id_now;
  logic [16:0] cnt, addr;
  int          err_total, cmp_count, seed, model_cnt;
  // open-drain wire with pull-up: low when either party pulls
  wire         sda_line = ~(m_oe | (sda_oe & ~sda_o));

  eir_bus_master m (.i_sda_line(sda_line), .o_scl(scl), .o_sda_oe(m_oe));

  eir_read_engine DUT (
    .i_clk(clk), .i_reset(rst), .i_ce(ce), .i_scl(scl), .i_sda(sda_line),
    .i_chip_select_pin_low(ce_lo), .i_chip_select_pin_high(ce_hi),
    .i_write_protect_n(wp_n), .i_write_busy(busy), .i_id_locked(locked),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_addr_counter(cnt), .o_id_mode(id_mode)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk_val(input string what, input logic [16:0] exp, input logic [16:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s exp %0h got %0h", what, exp, got);
    end
  endtask : chk_val

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_val(what, {16'h0000, exp}, {16'h0000, got});
  endtask : chk_bit

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    chk_val(what, {9'h000, exp}, {9'h000, got});
  endtask : chk_byte

  task automatic chk_cnt(input string what, input logic [16:0] exp, input logic [16:0] got);
    chk_val(what, exp, got);
  endtask : chk_cnt

  task automatic end_sim();
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic read_tail(input logic [3:0] typ, input int n);
    logic       a;
    logic [7:0] d;
    m.start_cond();
    m.wr_byte({typ, ce_hi, ce_lo, model_cnt[16], 1'b1}, a);
    chk_bit("read select ack", 1'b1, a);
    for (int k = 0; k < n; k++)
    begin
      m.rd_byte(k < n - 1, d);
      chk_byte("read data", 8'hFF, d);
      if (id_now)
        model_cnt = (model_cnt & 32'h1FF00) | ((model_cnt + 1) & 32'hFF);
      else
        model_cnt = (model_cnt + 1) & 32'h1FFFF;
      chk_cnt("address counter", model_cnt[16:0], cnt);
    end
    // nine more clocks after the no-ack must not move the counter; the byte seen is not compared
    m.rd_byte(1'b0, d);
    chk_cnt("counter after no-ack", model_cnt[16:0], cnt);
    chk_bit("id mode", id_now, id_mode);
    m.stop_cond();
    chk_bit("released after no-ack", 1'b0, sda_oe);
  endtask : read_tail

  task automatic rand_read(input logic [3:0] typ, input logic [16:0] a17, input int n);
    logic a;
    m.start_cond();
    m.wr_byte({typ, ce_hi, ce_lo, a17[16], 1'b0}, a);
    chk_bit("dummy write select ack", 1'b1, a);
    m.wr_byte(a17[15:8], a);
    chk_bit("high address ack", 1'b1, a);
    m.wr_byte(a17[7:0], a);
    chk_bit("low address ack", 1'b1, a);
    id_now = (typ == eir_pkg::TYPE_ID);
    model_cnt = id_now ? int'(a17[7:0]) : int'(a17);
    read_tail(typ, n);
  endtask : rand_read

  initial
  begin
    #1ms;
    err_total++;
    $display("[ERR] watchdog exp finish got timeout");
    end_sim();
  end

  initial
  begin
    {rst, ce} = 2'b11;
    {ce_lo, ce_hi, wp_n, busy, locked, id_now} = 6'b010000;
    err_total = 0;
    cmp_count = 0;
    model_cnt = 0;
    seed = 32'h5e80;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk_cnt("reset counter", 17'h00000, cnt);
    chk_bit("reset drive", 1'b0, sda_oe);
    chk_bit("reset id mode", 1'b0, id_mode);
    for (int t = 0; t < 4; t++)
    begin
      @(negedge clk);
      {ce_hi, ce_lo, wp_n} = 3'($random(seed));
      addr = 17'($random(seed));
      rand_read(eir_pkg::TYPE_ARRAY, addr, 1);
      id_now = 1'b0;
      read_tail(eir_pkg::TYPE_ARRAY, 2);
    end
    // clock enable low on an idle bus: counter and drive must hold
    @(negedge clk);
    ce = 1'b0;
    repeat (5) @(negedge clk);
    chk_cnt("counter frozen", model_cnt[16:0], cnt);
    chk_bit("drive frozen", 1'b0, sda_oe);
    ce = 1'b1;
    rand_read(eir_pkg::TYPE_ARRAY, 17'h1FFFE, 3);
    m.start_cond();
    m.wr_byte({eir_pkg::TYPE_ARRAY, ~ce_hi, ce_lo, 2'b01}, ack);
    chk_bit("foreign select ack", 1'b0, ack);
    m.stop_cond();
    @(negedge clk);
    busy = 1'b1;
    m.start_cond();
    m.wr_byte({eir_pkg::TYPE_ARRAY, ce_hi, ce_lo, 2'b01}, ack);
    chk_bit("busy select ack", 1'b0, ack);
    m.stop_cond();
    chk_cnt("counter kept while busy", model_cnt[16:0], cnt);
    @(negedge clk);
    busy = 1'b0;
    rand_read(eir_pkg::TYPE_ID, 17'h15AFE, 2);
    id_now = 1'b0;
    read_tail(eir_pkg::TYPE_ARRAY, 1);
    for (int lk = 0; lk < 2; lk++)
    begin
      @(negedge clk);
      locked = lk[0];
      m.start_cond();
      m.wr_byte({eir_pkg::TYPE_ID, ce_hi, ce_lo, 2'b00}, ack);
      m.wr_byte(8'h00, ack);
      m.wr_byte(8'h00, ack);
      m.wr_byte(8'h02, ack);
      chk_bit("lock status ack", ~locked, ack);
      m.start_cond();
      m.stop_cond();
      rand_read(eir_pkg::TYPE_ARRAY, 17'($random(seed)), 1);
    end
    end_sim();
  end
endmodule : tb_eeprom_i2c_read_engine
